// >>> core/sfb_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfb_cfg.svh"

module sfb_dev #(
  parameter int PAGES       = `SFB_PAGES,
  parameter int PAGE_MAX    = `SFB_PAGE_STD,
  parameter int PROG_CYCLES = `SFB_PROG_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic page_256,
  sfb_link.device   link,
  output logic      standby,
  output logic      busy
);
  localparam int MW = $clog2(PAGES * PAGE_MAX);
  localparam int BW = $clog2(2 * PAGE_MAX);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the host's serial clock

  logic        frame_rst;
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [6:0]  shreg;
  logic [7:0]  in_byte;
  logic        byte_end;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  rx_data;
  logic        cmd_tgl;
  logic        rx_tgl;
  logic        rq_tgl;
  logic [7:0]  out_sh;
  logic        out_oe;
  logic        rd_cls;
  logic        load;
  logic [7:0]  tx_data;

  // deselect holds the bit, byte and output shift logic in reset, so stray clocks do nothing
  assign frame_rst = rst | link.cs_n;
  assign in_byte   = {shreg, link.si};
  assign byte_end  = (bit_cnt == `SFB_LAST_BIT);
  assign rd_cls    = (opcode[7:4] == `SFB_CLS_RD) || (opcode[7:4] == `SFB_CLS_STAT);
  assign load      = (bit_cnt == 3'h0) && (byte_cnt == `SFB_RD_FIRST) && rd_cls;

  // positions count rising edges only, so idle level never matters
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shreg    <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= in_byte[6:0];
      if (byte_end && byte_cnt != `SFB_RD_FIRST) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // kept through deselect: the core reads these after the frame
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      opcode  <= 8'h00;
      addr    <= 24'h000000;
      rx_data <= 8'h00;
      cmd_tgl <= 1'b0;
      rx_tgl  <= 1'b0;
    end else if (byte_end) begin
      if (byte_cnt == 3'h0) begin
        opcode <= in_byte;
      end else if (byte_cnt < `SFB_HDR_BYTES) begin
        addr <= {addr[15:0], in_byte};
      end else if (opcode[7:4] == `SFB_CLS_WR) begin
        rx_data <= in_byte;
        rx_tgl  <= ~rx_tgl;
      end
      // only a full header reaches the core
      if (byte_cnt == `SFB_HDR_BYTES - 3'h1) begin
        cmd_tgl <= ~cmd_tgl;
      end
    end
  end

  // tx_data is held by the core for a whole byte time before this load
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_sh <= 8'h00;
      out_oe <= 1'b0;
    end else if (load) begin
      out_sh <= tx_data;
      out_oe <= 1'b1;
    end else begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // each loaded byte asks the core for the next one
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      rq_tgl <= 1'b0;
    end else if (load) begin
      rq_tgl <= ~rq_tgl;
    end
  end

  assign link.so    = out_sh[7];
  assign link.so_oe = out_oe;

  //////////////////////////////////////////////////////////////////////////////
  // crossings into the core clock

  logic [2:0] tg_s1;
  logic [2:0] tg_s2;
  logic [2:0] tg_s3;
  logic [2:0] tg_ev;
  logic       cs_s1;
  logic       cs_s2;
  logic       cmd_ev;
  logic       rx_ev;
  logic       rq_ev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tg_s1 <= 3'h0;
      tg_s2 <= 3'h0;
      tg_s3 <= 3'h0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end else begin
      tg_s1 <= {rq_tgl, rx_tgl, cmd_tgl};
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
    end
  end

  assign tg_ev  = tg_s2 ^ tg_s3;
  assign cmd_ev = tg_ev[0];
  assign rx_ev  = tg_ev[1];
  assign rq_ev  = tg_ev[2];

  //////////////////////////////////////////////////////////////////////////////
  // core: buffers, array and self-timed transfers

  sfb_pkg::sfb_core_t state;
  logic [3:0]  cls;
  logic        p2;
  logic [8:0]  page_len;
  logic [8:0]  byte_a;
  logic [11:0] page_a;
  logic        sel;
  logic        psel;
  logic [8:0]  ptr;
  logic [8:0]  next_ptr;
  logic [11:0] page;
  logic [8:0]  cnt;
  logic [TW-1:0] timer;
  logic        fetch_pend;
  logic        stat_rd;
  logic [BW-1:0] buf_idx;
  logic [BW-1:0] cb_idx;
  logic [MW-1:0] mem_idx;

  logic [7:0] bufm [0:2*PAGE_MAX-1];
  logic [7:0] mem  [0:PAGES*PAGE_MAX-1];

  assign cls      = opcode[7:4];
  assign page_len = p2 ? 9'(`SFB_PAGE_P2) : 9'(`SFB_PAGE_STD);
  // page size is sampled live at command time
  assign byte_a   = page_256 ? {1'b0, addr[7:0]} : addr[8:0];
  assign page_a   = page_256 ? addr[19:8] : addr[20:9];
  assign next_ptr = (ptr == page_len - 9'h001) ? 9'h000 : ptr + 9'h001;
  assign buf_idx  = BW'(int'(sel) * PAGE_MAX + int'(ptr));
  assign cb_idx   = BW'(int'(psel) * PAGE_MAX + int'(cnt));
  assign mem_idx  = MW'(int'(page) * PAGE_MAX + int'(cnt));

  // page size is frozen while a transfer runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p2 <= 1'b0;
    end else if (cmd_ev && state == sfb_pkg::CORE_IDLE) begin
      p2 <= page_256;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= sfb_pkg::CORE_IDLE;
      page  <= 12'h000;
      psel  <= 1'b0;
      cnt   <= 9'h000;
      timer <= '0;
    end else begin
      case (state)
        sfb_pkg::CORE_IDLE: begin
          if (cmd_ev && (cls == `SFB_CLS_PROG || cls == `SFB_CLS_LOAD)) begin
            page  <= page_a;
            psel  <= opcode[0];
            cnt   <= 9'h000;
            state <= (cls == `SFB_CLS_PROG) ? sfb_pkg::CORE_COPY_OUT : sfb_pkg::CORE_COPY_IN;
          end
        end
        sfb_pkg::CORE_COPY_OUT: begin
          cnt <= cnt + 9'h001;
          if (cnt == page_len - 9'h001) begin
            timer <= '0;
            state <= sfb_pkg::CORE_TIMED;
          end
        end
        sfb_pkg::CORE_COPY_IN: begin
          cnt <= cnt + 9'h001;
          if (cnt == page_len - 9'h001) begin
            state <= sfb_pkg::CORE_IDLE;
          end
        end
        sfb_pkg::CORE_TIMED: begin
          timer <= timer + TW'(1);
          if (timer == TW'(PROG_CYCLES - 1)) begin
            state <= sfb_pkg::CORE_IDLE;
          end
        end
        default: begin
          state <= sfb_pkg::CORE_IDLE;
        end
      endcase
    end
  end

  // buffer pointer and read prefetch; fetch lags the command by a cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel        <= 1'b0;
      ptr        <= 9'h000;
      fetch_pend <= 1'b0;
      stat_rd    <= 1'b0;
      tx_data    <= 8'h00;
    end else begin
      fetch_pend <= 1'b0;
      if (cmd_ev) begin
        stat_rd <= (cls == `SFB_CLS_STAT);
        if (cls == `SFB_CLS_WR || cls == `SFB_CLS_RD) begin
          sel <= opcode[0];
          ptr <= byte_a;
        end
        fetch_pend <= (cls == `SFB_CLS_RD || cls == `SFB_CLS_STAT);
      end else if (fetch_pend || rq_ev) begin
        if (stat_rd) begin
          tx_data                 <= 8'h00;
          tx_data[`SFB_STAT_BUSY] <= (state != sfb_pkg::CORE_IDLE);
          tx_data[`SFB_STAT_P2]   <= p2;
        end else begin
          tx_data <= bufm[buf_idx];
          ptr     <= next_ptr;
        end
      end else if (rx_ev) begin
        ptr <= next_ptr;
      end
    end
  end

  // host writes are never blocked by a busy array
  always_ff @(posedge mclk) begin
    if (rx_ev) begin
      bufm[buf_idx] <= rx_data;
    end
    if (state == sfb_pkg::CORE_COPY_IN) begin
      bufm[cb_idx] <= mem[mem_idx];
    end
  end

  always_ff @(posedge mclk) begin
    if (state == sfb_pkg::CORE_COPY_OUT) begin
      mem[mem_idx] <= bufm[cb_idx];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy    <= 1'b0;
      standby <= 1'b1;
    end else begin
      busy    <= (state != sfb_pkg::CORE_IDLE);
      standby <= cs_s2 && (state == sfb_pkg::CORE_IDLE);
    end
  end
endmodule

`default_nettype wire

// >>> core/sfb_cfg.svh
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

// frame layout
`define SFB_HDR_BYTES   3'h4
`define SFB_RD_FIRST    3'h5
`define SFB_LAST_BIT    3'h7

// command classes, opcode[7:4]; opcode[0] picks the buffer
`define SFB_CLS_WR      4'h1
`define SFB_CLS_RD      4'h2
`define SFB_CLS_PROG    4'h3
`define SFB_CLS_LOAD    4'h4
`define SFB_CLS_STAT    4'h5

// array geometry
`define SFB_PAGES       4096
`define SFB_PAGE_STD    264
`define SFB_PAGE_P2     256

// status byte
`define SFB_STAT_BUSY   7
`define SFB_STAT_P2     0

// timing
`define SFB_PROG_CYCLES 200
`define SFB_SCLK_HALF   4
`define SFB_CS_GAP      4

`endif

// >>> core/sfb_pkg.sv
`default_nettype none

package sfb_pkg;

  typedef enum logic [1:0] {
    CORE_IDLE,
    CORE_COPY_OUT,
    CORE_COPY_IN,
    CORE_TIMED
  } sfb_core_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_LOAD,
    HOST_BIT,
    HOST_GAP
  } sfb_host_t;

endpackage

`default_nettype wire

// >>> core/sfb_link.sv
`timescale 1ns/1ps
`default_nettype none

interface sfb_link;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // released output line reads high, as through a pull-up
  assign so_line = so_oe ? so : 1'b1;

  modport device (
    input  sclk,
    input  cs_n,
    input  si,
    output so,
    output so_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output si,
    input  so_line
  );
endinterface

`default_nettype wire

// >>> core/sfb_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sfb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] store [0:D-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

`default_nettype wire

// >>> core/sfb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfb_cfg.svh"

module sfb_host #(
  parameter int HALF = `SFB_SCLK_HALF,
  parameter int GAP  = `SFB_CS_GAP,
  parameter int LW   = 9,
  parameter int FD   = 8
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          mode3,
  input  wire logic          start,
  input  wire logic [7:0]    op,
  input  wire logic [23:0]   addr,
  input  wire logic [LW-1:0] wlen,
  input  wire logic [LW-1:0] rlen,
  input  wire logic [7:0]    wr_data,
  input  wire logic          wr_valid,
  output logic               wr_ready,
  output logic [7:0]         rd_data,
  output logic               rd_valid,
  output logic               busy,
  output logic               done,
  sfb_link.host              link
);
  sfb_pkg::sfb_host_t state;
  logic [7:0]    phase;
  logic [2:0]    bit_i;
  logic [LW:0]   byte_i;
  logic [LW:0]   total;
  logic [7:0]    sh_out;
  logic [7:0]    sh_in;
  logic [7:0]    r_op;
  logic [23:0]   r_addr;
  logic [LW-1:0] r_wlen;
  logic [LW-1:0] r_rlen;
  logic          r_mode3;
  logic          sclk_q;
  logic          cs_q;
  logic          si_q;
  logic          so_s1;
  logic          so_s2;
  logic [7:0]    gap_cnt;
  logic          is_rd;
  logic          need_fifo;
  logic          last;
  logic [7:0]    next_byte;
  logic          f_valid;
  logic          f_ready;
  logic [7:0]    f_data;

  // write data waits here; an empty fifo stalls the clock mid-frame
  sfb_fifo #(.W(8), .D(FD)) u_fifo (
    .clk       (mclk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign is_rd     = (r_rlen != '0);
  assign total     = is_rd ? (LW+1)'(`SFB_HDR_BYTES) + (LW+1)'(r_rlen) + (LW+1)'(1)
                           : (LW+1)'(`SFB_HDR_BYTES) + (LW+1)'(r_wlen);
  assign last      = (byte_i == total);
  assign need_fifo = !is_rd && (byte_i >= (LW+1)'(`SFB_HDR_BYTES));
  assign f_ready   = (state == sfb_pkg::HOST_LOAD) && need_fifo && !last;

  always_comb begin
    case (byte_i)
      (LW+1)'(0): next_byte = r_op;
      (LW+1)'(1): next_byte = r_addr[23:16];
      (LW+1)'(2): next_byte = r_addr[15:8];
      (LW+1)'(3): next_byte = r_addr[7:0];
      default:    next_byte = is_rd ? 8'h00 : f_data;
    endcase
  end

  // returned line is a pin to this clock: two flops before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_s1 <= 1'b1;
      so_s2 <= 1'b1;
    end else begin
      so_s1 <= link.so_line;
      so_s2 <= so_s1;
    end
  end

  // clock is mclk / (2*HALF); HALF below 3 outruns the return sync
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state    <= sfb_pkg::HOST_IDLE;
      phase    <= 8'h00;
      bit_i    <= 3'h0;
      byte_i   <= '0;
      sh_out   <= 8'h00;
      sh_in    <= 8'h00;
      r_op     <= 8'h00;
      r_addr   <= 24'h000000;
      r_wlen   <= '0;
      r_rlen   <= '0;
      r_mode3  <= 1'b0;
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      si_q     <= 1'b0;
      gap_cnt  <= 8'h00;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (state)
        sfb_pkg::HOST_IDLE: begin
          sclk_q <= mode3;
          if (start) begin
            r_op    <= op;
            r_addr  <= addr;
            r_wlen  <= wlen;
            r_rlen  <= rlen;
            r_mode3 <= mode3;
            byte_i  <= '0;
            cs_q    <= 1'b0;
            busy    <= 1'b1;
            state   <= sfb_pkg::HOST_LOAD;
          end
        end
        sfb_pkg::HOST_LOAD: begin
          if (last) begin
            cs_q    <= 1'b1;
            sclk_q  <= r_mode3;
            gap_cnt <= 8'h00;
            state   <= sfb_pkg::HOST_GAP;
          end else if (!need_fifo || f_valid) begin
            sh_out <= next_byte;
            si_q   <= next_byte[7];
            sclk_q <= 1'b0;
            phase  <= 8'h00;
            bit_i  <= 3'h0;
            state  <= sfb_pkg::HOST_BIT;
          end
        end
        sfb_pkg::HOST_BIT: begin
          phase <= phase + 8'h01;
          if (phase == 8'(HALF - 1)) begin
            sclk_q <= 1'b1;
            sh_in  <= {sh_in[6:0], so_s2};
          end else if (phase == 8'(2 * HALF - 1)) begin
            if (bit_i == `SFB_LAST_BIT) begin
              if (is_rd && byte_i >= (LW+1)'(`SFB_RD_FIRST)) begin
                rd_data  <= sh_in;
                rd_valid <= 1'b1;
              end
              byte_i <= byte_i + (LW+1)'(1);
              state  <= sfb_pkg::HOST_LOAD;
            end else begin
              bit_i  <= bit_i + 3'h1;
              sh_out <= {sh_out[6:0], 1'b0};
              si_q   <= sh_out[6];
              sclk_q <= 1'b0;
              phase  <= 8'h00;
            end
          end
        end
        sfb_pkg::HOST_GAP: begin
          gap_cnt <= gap_cnt + 8'h01;
          if (gap_cnt == 8'(GAP - 1)) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= sfb_pkg::HOST_IDLE;
          end
        end
        default: begin
          state <= sfb_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.si   = si_q;
endmodule

`default_nettype wire

// >>> tb/sfb_link_props.sv
`timescale 1ns/1ps
`default_nettype none

module sfb_link_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line,
  input wire logic mode3,
  input wire logic standby,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_sel;
    $fell(cs_n);
  endsequence
  // six cycles covers the select synchroniser plus the status register
  sequence s_quiet;
    (cs_n && !busy) [*6];
  endsequence

  property p_line_idle;
    !so_oe |-> so_line;
  endproperty
  property p_desel_off;
    cs_n |-> !so_oe;
  endproperty
  property p_hdr_quiet;
    s_sel |-> (!so_oe) [*8];
  endproperty
  property p_start_idle;
    s_sel |-> sclk == mode3;
  endproperty
  property p_si_hold;
    !cs_n && $rose(sclk) |-> $stable(si);
  endproperty
  property p_so_fall;
    so_oe && $changed(so) |-> $fell(sclk);
  endproperty
  property p_oe_fall;
    $rose(so_oe) |-> $fell(sclk);
  endproperty
  property p_sel_wake;
    s_sel |-> ##[1:6] !standby;
  endproperty
  property p_quiet_standby;
    s_quiet |-> standby;
  endproperty
  property p_busy_awake;
    busy |-> !standby;
  endproperty
  // every clock level lasts at least two samples, so the clock stays well under the ceiling
  property p_clk_rate;
    $changed(sclk) |=> $stable(sclk);
  endproperty

  ////////////////////////////////////////////////////////////////////////////
  a_line_idle: assert property (p_line_idle)
    else $error("released output line not high");
  a_desel_off: assert property (p_desel_off)
    else $error("output driven while deselected");
  a_hdr_quiet: assert property (p_hdr_quiet)
    else $error("output driven during header");
  a_start_idle: assert property (p_start_idle)
    else $error("clock not at mode idle level at select");
  a_si_hold: assert property (p_si_hold)
    else $error("input data moved at sampling edge");
  a_so_fall: assert property (p_so_fall)
    else $error("output data moved off falling clock");
  a_oe_fall: assert property (p_oe_fall)
    else $error("output enable rose off falling clock");
  a_sel_wake: assert property (p_sel_wake)
    else $error("select did not leave standby");
  a_quiet_standby: assert property (p_quiet_standby)
    else $error("idle deselected device not in standby");
  a_busy_awake: assert property (p_busy_awake)
    else $error("standby while timed work runs");
  a_clk_rate: assert property (p_clk_rate)
    else $error("serial clock level shorter than two core cycles");
endmodule

`default_nettype wire

// >>> tb/serial_flash_bus_frontend_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module serial_flash_bus_frontend_tb_top;
  typedef struct packed {
    logic        p256;
    logic        mode3;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [8:0]  wlen;
    logic [8:0]  rlen;
    logic [7:0]  base;
  } sfb_row_t;

  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        mode3    = 1'b0;
  logic        start    = 1'b0;
  logic [7:0]  op       = 8'h00;
  logic [23:0] addr     = 24'h000000;
  logic [8:0]  wlen     = 9'h000;
  logic [8:0]  rlen     = 9'h000;
  logic [7:0]  wr_data  = 8'h00;
  logic        wr_valid = 1'b0;
  logic        page_256 = 1'b0;
  logic        wr_ready;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        h_busy;
  logic        done;
  logic        standby;
  logic        d_busy;
  int          bad_count;
  int          total_checks;
  int          cycles;
  int          n;
  sfb_row_t    rows [14];

  always #5 mclk = ~mclk;

  sfb_link i_sfb_link ();
  sfb_host i_sfb_host (
    .mclk(mclk), .rst(rst), .mode3(mode3), .start(start), .op(op), .addr(addr),
    .wlen(wlen), .rlen(rlen), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .busy(h_busy),
    .done(done), .link(i_sfb_link)
  );
  // short timed phase keeps the run small
  sfb_dev #(.PROG_CYCLES(10)) i_sfb_dev (
    .mclk(mclk), .rst(rst), .page_256(page_256), .link(i_sfb_link),
    .standby(standby), .busy(d_busy)
  );
  sfb_link_props i_sfb_link_props (
    .mclk(mclk), .rst(rst), .sclk(i_sfb_link.sclk), .cs_n(i_sfb_link.cs_n),
    .si(i_sfb_link.si), .so(i_sfb_link.so), .so_oe(i_sfb_link.so_oe),
    .so_line(i_sfb_link.so_line), .mode3(mode3), .standby(standby), .busy(d_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic issue(input sfb_row_t r);
    op = r.op;
    addr = r.addr;
    wlen = r.wlen;
    rlen = r.rlen;
    start = 1'b1;
    tick();
    start = 1'b0;
  endtask

  task automatic run(input sfb_row_t r, input bit fill);
    int k;
    k = 0;
    page_256 = r.p256;
    mode3 = r.mode3;
    // program, load and status wait for the core so none is ignored
    for (int t = 0; t < 2000 && r.op[7:4] >= 4'h3 && d_busy !== 1'b0; t++) tick();
    for (int i = 0; i < r.wlen && fill; i++) begin
      wr_data = r.base + 8'(i);
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) tick();
      tick();
    end
    wr_valid = 1'b0;
    repeat (3) tick();
    issue(r);
    for (int t = 0; t < 3000 && done !== 1'b1; t++) begin
      if (rd_valid === 1'b1 && r.op[7:4] == 4'h5) check(rd_data & 8'h81, {7'h00, r.p256});
      else if (rd_valid === 1'b1) check(rd_data, r.base + 8'(k));
      if (rd_valid === 1'b1) k++;
      tick();
    end
    check(done, 8'h01);
    check(8'(k), r.rlen[7:0]);
    if (r.op[7:4] inside {4'h3, 4'h4}) begin
      check(d_busy, 8'h01);
      check(standby, 8'h00);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    rows = '{
      '{1'b0, 1'b0, 8'h10, 24'h000010, 9'h004, 9'h000, 8'ha0},
      '{1'b0, 1'b1, 8'h20, 24'h000010, 9'h000, 9'h004, 8'ha0},
      '{1'b0, 1'b0, 8'h30, 24'h000a00, 9'h000, 9'h000, 8'h00},
      '{1'b0, 1'b1, 8'h11, 24'h000010, 9'h004, 9'h000, 8'h60},
      '{1'b0, 1'b0, 8'h21, 24'h000010, 9'h000, 9'h004, 8'h60},
      '{1'b0, 1'b1, 8'h41, 24'h000a00, 9'h000, 9'h000, 8'h00},
      '{1'b0, 1'b0, 8'h21, 24'h000010, 9'h000, 9'h004, 8'ha0},
      '{1'b0, 1'b1, 8'h50, 24'h000000, 9'h000, 9'h001, 8'h00},
      '{1'b1, 1'b0, 8'h10, 24'h000020, 9'h004, 9'h000, 8'h50},
      '{1'b1, 1'b1, 8'h30, 24'h000700, 9'h000, 9'h000, 8'h00},
      '{1'b1, 1'b0, 8'h41, 24'h000700, 9'h000, 9'h000, 8'h00},
      '{1'b1, 1'b1, 8'h50, 24'h000000, 9'h000, 9'h001, 8'h00},
      '{1'b1, 1'b0, 8'h10, 24'h000040, 9'h008, 9'h000, 8'hc0},
      '{1'b1, 1'b1, 8'h20, 24'h000040, 9'h000, 9'h008, 8'hc0}
    };
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    check(standby, 8'h01);
    check(i_sfb_link.so_line, 8'h01);
    // row 3's write to the other buffer starts while the program still runs and lands after it ends
    for (int i = 0; i < 12; i++) run(rows[i], 1'b1);
    // fifo fills to its depth and then refuses
    n = 0;
    for (int i = 0; i < 10; i++) begin
      wr_data = 8'hc0 + 8'(i);
      wr_valid = 1'b1;
      if (wr_ready === 1'b1) n++;
      tick();
    end
    wr_valid = 1'b0;
    check(8'(n), 8'h08);
    check(wr_ready, 8'h00);
    run(rows[12], 1'b0);
    check(wr_ready, 8'h01);
    run(rows[13], 1'b0);
    // reset in mid-frame, then a fresh frame must still work
    issue(rows[13]);
    repeat (100) tick();
    rst = 1'b1;
    tick();
    check(i_sfb_link.cs_n, 8'h01);
    check(i_sfb_link.so_oe, 8'h00);
    check(h_busy, 8'h00);
    // reset spans two core edges before release
    tick();
    rst = 1'b0;
    tick();
    run(rows[11], 1'b1);
    wrap_up();
  end
endmodule

`default_nettype wire
